// >>> ccc_conv_ctrl.sv
// converter conversion control: register port, clock divider, conversion sequencer,
// trigger edge detect, channel decode, result hold and interrupt
// assumes the analog core samples and converts on the controls given here and
// presents a steady 10-bit result at the last cycle of a conversion
//
// Notes on behaviour
// - decode upper channel codes to pairs, gains
// - enable bit switches converter on and off
// - clearing enable aborts a running conversion
// - single mode: one start write, one conversion
// - free running: first start, then continuous
// - first conversion 25 cycles, later 13
// - start bit reads one while converting
// - writing zero to start does nothing
// - auto trigger starts on selected rising edge
// - completion flag set at completion, even if result locked
// - interrupt when flag, enable, global enable
// - vector entry clears the completion flag
// - write one clears flag, zero keeps
// - divider field picks system clock division
// - channel change applies from next conversion
// - low byte read holds result until high
// - free running selection makes no trigger
`timescale 1ns/1ns

module ccc_conv_ctrl #(
   parameter int TRIG_WIDTH = 8
) (
   // clock and reset
   input  wire logic                   MCLK_IN,
   input  wire logic                   RST_N_IN,
   // register port
   input  wire logic [7:0]             REG_ADDR_IN,
   input  wire logic [7:0]             REG_WDATA_IN,
   input  wire logic                   REG_WR_IN,
   input  wire logic                   REG_RD_IN,
   output logic      [7:0]             REG_RDATA_OUT,
   // processor interrupt side
   input  wire logic                   GLOBAL_IE_IN,
   input  wire logic                   VECTOR_ACK_IN,
   output logic                        IRQ_OUT,
   // trigger sources, bit 0 unused (free running)
   input  wire logic [TRIG_WIDTH-1:0]  TRIGGER_IN,
   // analog core
   input  wire logic [9:0]             ANA_RESULT_IN,
   output logic                        ANA_POWER_OUT,
   output logic                        ANA_TICK_OUT,
   output logic                        ANA_SAMPLE_OUT,
   output logic                        ANA_CONVERT_OUT,
   output ccc_pkg::ccc_route_s         ANA_ROUTE_OUT
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic ccc_pkg::ccc_route_s decode_route(input logic [5:0] code);
      ccc_pkg::ccc_route_s r;
      r              = '0;
      r.code         = code;
      r.gain         = ccc_pkg::CCC_GAIN_1;
      if (code[5:3] == 3'h5) begin
         // pairs on 8/9 or 10/11, gain picked by bit 1
         r.upper_valid  = 1'b1;
         r.differential = 1'b1;
         r.neg_input    = code[2] ? 4'ha : 4'h8;
         r.pos_input    = r.neg_input + {3'h0, code[0]};
         r.gain         = code[1] ? ccc_pkg::CCC_GAIN_200 : ccc_pkg::CCC_GAIN_10;
      end else if (code[5:3] == 3'h6) begin
         r.upper_valid  = 1'b1;
         r.differential = 1'b1;
         r.pos_input    = {1'b1, code[2:0]};
         r.neg_input    = 4'h9;
      end else if (code[5:3] == 3'h7) begin
         r.upper_valid  = 1'b1;
         if (code[2:1] == 2'h3) begin
            r.reserved     = 1'b1;
         end else begin
            r.differential = 1'b1;
            r.pos_input    = {1'b1, code[2:0]};
            r.neg_input    = 4'ha;
         end
      end
      return r;
   endfunction

   // division mask: converter tick when the low bits of the prescaler are all ones
   function automatic logic [6:0] div_mask(input logic [2:0] sel);
      logic [6:0] m;
      m = 7'h01;
      case (sel)
         3'h0, 3'h1: m = 7'h01;
         3'h2:       m = 7'h03;
         3'h3:       m = 7'h07;
         3'h4:       m = 7'h0f;
         3'h5:       m = 7'h1f;
         3'h6:       m = 7'h3f;
         default:    m = 7'h7f;
      endcase
      return m;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ccc_pkg::ccc_state_s s;
   ccc_pkg::ccc_state_s next_s;

   logic                tick;
   logic                wr_cs;
   logic                trig_level;
   logic                trig_edge;
   logic                free_running;
   logic                start_req;
   logic                complete;
   logic                abort;
   logic [4:0]          conv_len;
   logic [4:0]          sample_len;
   logic                done_clr;
   logic                abort_clr;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s       = s;
      wr_cs        = REG_WR_IN && (REG_ADDR_IN == ccc_pkg::CONTROL_STATUS_OFFSET);
      tick         = s.enable && ((s.pre & div_mask(s.div_sel)) == div_mask(s.div_sel));
      free_running = s.auto_trig && (s.trig_sel == ccc_pkg::TRIG_FREE_RUNNING);
      conv_len     = s.first_active ? ccc_pkg::FIRST_CONV_CYCLES
                                    : ccc_pkg::NORMAL_CONV_CYCLES;
      sample_len   = s.first_active ? ccc_pkg::FIRST_SAMPLE_CYCLES
                                    : ccc_pkg::NORMAL_SAMPLE_CYCLES;
      complete     = (s.conv == ccc_pkg::CCC_RUN) && tick
                     && (s.cyc == conv_len - 5'h01);
      // free running takes no edge here, so selecting it never fires a start
      trig_level   = (s.trig_sel == ccc_pkg::TRIG_FREE_RUNNING) ? 1'b0
                                                               : TRIGGER_IN[s.trig_sel];
      trig_edge    = s.enable && s.auto_trig && trig_level && !s.trig_prev;
      next_s.trig_prev = trig_level;

      // prescaler runs only while the converter is on
      next_s.pre   = s.enable ? s.pre + 7'h01 : 7'h00;

      // ---------------- register writes ----------------
      abort        = 1'b0;
      start_req    = 1'b0;
      if (wr_cs) begin
         next_s.enable    = REG_WDATA_IN[ccc_pkg::CS_ENABLE_BIT];
         next_s.auto_trig = REG_WDATA_IN[ccc_pkg::CS_AUTO_BIT];
         next_s.done_ie   = REG_WDATA_IN[ccc_pkg::CS_DONE_IE_BIT];
         next_s.div_sel   = REG_WDATA_IN[ccc_pkg::CS_DIV_LSB +: 3];
         if (REG_WDATA_IN[ccc_pkg::CS_ENABLE_BIT] && !s.enable) begin
            next_s.first_pending = 1'b1;
         end
         if (!REG_WDATA_IN[ccc_pkg::CS_ENABLE_BIT] && s.conv == ccc_pkg::CCC_RUN) begin
            abort = 1'b1;
         end
         // a zero in the start position is simply not a request
         start_req = REG_WDATA_IN[ccc_pkg::CS_START_BIT]
                     && REG_WDATA_IN[ccc_pkg::CS_ENABLE_BIT];
      end else if (REG_WR_IN && REG_ADDR_IN == ccc_pkg::TRIGGER_MUX_OFFSET) begin
         next_s.trig_sel    = REG_WDATA_IN[ccc_pkg::TM_TRIG_LSB +: 3];
         next_s.chan_sel[5] = REG_WDATA_IN[ccc_pkg::TM_MUX_TOP_BIT];
      end else if (REG_WR_IN && REG_ADDR_IN == ccc_pkg::CHANNEL_OFFSET) begin
         next_s.left_adj      = REG_WDATA_IN[ccc_pkg::CH_LEFT_ADJ_BIT];
         next_s.chan_sel[4:0] = REG_WDATA_IN[ccc_pkg::CH_MUX_LSB +: 5];
      end else if (REG_WR_IN && REG_ADDR_IN == ccc_pkg::IRQ_MASK_OFFSET) begin
         next_s.done_ie  = REG_WDATA_IN[ccc_pkg::IRQ_DONE_BIT];
         next_s.abort_ie = REG_WDATA_IN[ccc_pkg::IRQ_ABORT_BIT];
      end
      start_req = start_req || trig_edge;

      // ---------------- conversion sequencer ----------------
      case (s.conv)
         ccc_pkg::CCC_IDLE: begin
            if (start_req) begin
               next_s.conv          = ccc_pkg::CCC_RUN;
               next_s.cyc           = 5'h00;
               next_s.first_active  = next_s.first_pending;
               next_s.first_pending = 1'b0;
               // channel is taken at the start so later writes wait a conversion
               next_s.route         = decode_route(next_s.chan_sel);
            end
         end
         ccc_pkg::CCC_RUN: begin
            if (abort) begin
               next_s.conv = ccc_pkg::CCC_IDLE;
               next_s.cyc  = 5'h00;
            end else if (complete) begin
               if (!s.lock) begin
                  next_s.result = ANA_RESULT_IN;
               end
               next_s.first_active = 1'b0;
               next_s.cyc          = 5'h00;
               if (free_running) begin
                  next_s.conv  = ccc_pkg::CCC_RUN;
                  next_s.route = decode_route(s.chan_sel);
               end else begin
                  next_s.conv  = ccc_pkg::CCC_IDLE;
               end
            end else if (tick) begin
               next_s.cyc = s.cyc + 5'h01;
            end
         end
         default: begin
            next_s.conv = ccc_pkg::CCC_IDLE;
         end
      endcase

      // ---------------- sticky flags, set beats clear ----------------
      done_clr  = (wr_cs && REG_WDATA_IN[ccc_pkg::CS_DONE_BIT])
                  || (REG_WR_IN && REG_ADDR_IN == ccc_pkg::IRQ_STATUS_OFFSET
                      && REG_WDATA_IN[ccc_pkg::IRQ_DONE_BIT])
                  || VECTOR_ACK_IN;
      abort_clr = REG_WR_IN && REG_ADDR_IN == ccc_pkg::IRQ_STATUS_OFFSET
                  && REG_WDATA_IN[ccc_pkg::IRQ_ABORT_BIT];
      // a completion that meets a disabling write is an abort, so it raises the abort flag and no completion flag
      next_s.done_flag  = (complete && !abort) || (s.done_flag && !done_clr);
      next_s.abort_flag = abort || (s.abort_flag && !abort_clr);

      // ---------------- reads, data stand one cycle ----------------
      next_s.rdata = 8'h00;
      if (REG_RD_IN) begin
         if (REG_ADDR_IN == ccc_pkg::CONTROL_STATUS_OFFSET) begin
            next_s.rdata = {s.enable, (s.conv == ccc_pkg::CCC_RUN), s.auto_trig,
                            s.done_flag, s.done_ie, s.div_sel};
         end else if (REG_ADDR_IN == ccc_pkg::TRIGGER_MUX_OFFSET) begin
            next_s.rdata = {4'h0, s.chan_sel[5], s.trig_sel};
         end else if (REG_ADDR_IN == ccc_pkg::CHANNEL_OFFSET) begin
            next_s.rdata = {2'h0, s.left_adj, s.chan_sel[4:0]};
         end else if (REG_ADDR_IN == ccc_pkg::RESULT_LOW_OFFSET) begin
            next_s.rdata = s.left_adj ? {s.result[1:0], 6'h00} : s.result[7:0];
            next_s.lock  = 1'b1;
         end else if (REG_ADDR_IN == ccc_pkg::RESULT_HIGH_OFFSET) begin
            next_s.rdata = s.left_adj ? s.result[9:2] : {6'h00, s.result[9:8]};
            next_s.lock  = 1'b0;
         end else if (REG_ADDR_IN == ccc_pkg::IRQ_STATUS_OFFSET) begin
            next_s.rdata = {6'h00, s.abort_flag, s.done_flag};
         end else if (REG_ADDR_IN == ccc_pkg::IRQ_MASK_OFFSET) begin
            next_s.rdata = {6'h00, s.abort_ie, s.done_ie};
         end else begin
            next_s.rdata = 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         s <= ccc_pkg::STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign REG_RDATA_OUT   = s.rdata;
   assign IRQ_OUT         = GLOBAL_IE_IN && ((s.done_flag && s.done_ie)
                                             || (s.abort_flag && s.abort_ie));
   assign ANA_POWER_OUT   = s.enable;
   assign ANA_TICK_OUT    = tick;
   assign ANA_SAMPLE_OUT  = (s.conv == ccc_pkg::CCC_RUN) && (s.cyc < sample_len);
   assign ANA_CONVERT_OUT = (s.conv == ccc_pkg::CCC_RUN) && (s.cyc >= sample_len);
   assign ANA_ROUTE_OUT   = s.route;

endmodule

// >>> ccc_pkg.sv
// constants and types for the converter conversion control block
// assumes one system clock, synchronous active-low reset and an 8-bit register port
package ccc_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] RESULT_LOW_OFFSET     = 8'h78;
   localparam logic [7:0] RESULT_HIGH_OFFSET    = 8'h79;
   localparam logic [7:0] CONTROL_STATUS_OFFSET = 8'h7a;
   localparam logic [7:0] TRIGGER_MUX_OFFSET    = 8'h7b;
   localparam logic [7:0] CHANNEL_OFFSET        = 8'h7c;
   localparam logic [7:0] IRQ_STATUS_OFFSET     = 8'h70;
   localparam logic [7:0] IRQ_MASK_OFFSET       = 8'h71;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CS_ENABLE_BIT   = 7;
   localparam int CS_START_BIT    = 6;
   localparam int CS_AUTO_BIT     = 5;
   localparam int CS_DONE_BIT     = 4;
   localparam int CS_DONE_IE_BIT  = 3;
   localparam int CS_DIV_LSB      = 0;
   localparam int TM_MUX_TOP_BIT  = 3;
   localparam int TM_TRIG_LSB     = 0;
   localparam int CH_LEFT_ADJ_BIT = 5;
   localparam int CH_MUX_LSB      = 0;
   localparam int IRQ_DONE_BIT    = 0;
   localparam int IRQ_ABORT_BIT   = 1;

   // ----------------------------------------------------------------
   // timing in converter clock cycles
   // ----------------------------------------------------------------
   localparam logic [4:0] FIRST_CONV_CYCLES  = 5'h19;
   localparam logic [4:0] NORMAL_CONV_CYCLES = 5'h0d;
   localparam logic [4:0] FIRST_SAMPLE_CYCLES  = 5'h0e;
   localparam logic [4:0] NORMAL_SAMPLE_CYCLES = 5'h02;
   localparam logic [2:0] TRIG_FREE_RUNNING    = 3'h0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      CCC_IDLE = 1'b0,
      CCC_RUN  = 1'b1
   } ccc_conv_e;

   typedef enum logic [1:0] {
      CCC_GAIN_1   = 2'b00,
      CCC_GAIN_10  = 2'b01,
      CCC_GAIN_200 = 2'b10
   } ccc_gain_e;

   typedef struct packed {
      logic       upper_valid;
      logic       differential;
      logic       reserved;
      logic [3:0] pos_input;
      logic [3:0] neg_input;
      ccc_gain_e  gain;
      logic [5:0] code;
   } ccc_route_s;

   typedef struct packed {
      logic       enable;
      logic       auto_trig;
      logic       done_flag;
      logic       done_ie;
      logic [2:0] div_sel;
      logic [2:0] trig_sel;
      logic [5:0] chan_sel;
      logic       left_adj;
      logic       abort_flag;
      logic       abort_ie;
      ccc_conv_e  conv;
      logic       first_pending;
      logic       first_active;
      logic [4:0] cyc;
      logic [6:0] pre;
      ccc_route_s route;
      logic [9:0] result;
      logic       lock;
      logic       trig_prev;
      logic [7:0] rdata;
   } ccc_state_s;

   localparam ccc_state_s STATE_RESET = '0;

endpackage

// >>> ccc_conv_ctrl_asserts.sv
// concurrent checks on the ports of the conversion control block
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ns

module ccc_conv_ctrl_asserts (
   // clock, reset, register port
   input wire logic                MCLK_IN,
   input wire logic                RST_N_IN,
   input wire logic [7:0]          REG_ADDR_IN,
   input wire logic [7:0]          REG_WDATA_IN,
   input wire logic                REG_WR_IN,
   // interrupt and analog core
   input wire logic                IRQ_OUT,
   input wire logic                ANA_POWER_OUT,
   input wire logic                ANA_TICK_OUT,
   input wire logic                ANA_SAMPLE_OUT,
   input wire logic                ANA_CONVERT_OUT,
   input wire ccc_pkg::ccc_route_s ANA_ROUTE_OUT
);
   logic ctl_wr;
   logic run;
   assign ctl_wr = REG_WR_IN && REG_ADDR_IN == 8'h7a;
   assign run = ANA_SAMPLE_OUT || ANA_CONVERT_OUT;
   default clocking dc @(posedge MCLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_power_follows: assert property (
      ctl_wr |=> ANA_POWER_OUT == $past(REG_WDATA_IN[7])) else $error("power differs");
   a_abort_halts: assert property (
      ctl_wr && !REG_WDATA_IN[7] |=> !run) else $error("run survives disable");
   a_start_samples: assert property (
      ctl_wr && REG_WDATA_IN[7:6] == 2'b11 && !run |=> ANA_SAMPLE_OUT)
      else $error("start write ignored");
   a_phase_exclusive: assert property (
      !(ANA_SAMPLE_OUT && ANA_CONVERT_OUT)) else $error("sample and convert together");
   a_end_on_tick: assert property (
      $fell(ANA_CONVERT_OUT) |-> $past(ANA_TICK_OUT) || !ANA_POWER_OUT)
      else $error("conversion ended off a tick");
   a_tick_spacing: assert property (
      ANA_TICK_OUT |=> !ANA_TICK_OUT) else $error("ticks closer than two cycles");
   a_route_held: assert property (
      ANA_CONVERT_OUT && $past(ANA_CONVERT_OUT) |-> $stable(ANA_ROUTE_OUT))
      else $error("route changed mid conversion");
   a_gain_pairs: assert property (
      ANA_ROUTE_OUT.upper_valid && ANA_ROUTE_OUT.code[4:3] == 2'b01
      |-> ANA_ROUTE_OUT.differential && ANA_ROUTE_OUT.gain != ccc_pkg::CCC_GAIN_1)
      else $error("gain pair decode wrong");
   c_start: cover property (ctl_wr && REG_WDATA_IN[7:6] == 2'b11);
   c_abort: cover property ($fell(ANA_CONVERT_OUT) && !ANA_POWER_OUT);
   c_irq: cover property ($rose(IRQ_OUT));
endmodule

bind ccc_conv_ctrl ccc_conv_ctrl_asserts u_asserts (
   .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .IRQ_OUT(IRQ_OUT),
   .ANA_POWER_OUT(ANA_POWER_OUT), .ANA_TICK_OUT(ANA_TICK_OUT),
   .ANA_SAMPLE_OUT(ANA_SAMPLE_OUT), .ANA_CONVERT_OUT(ANA_CONVERT_OUT),
   .ANA_ROUTE_OUT(ANA_ROUTE_OUT));

// >>> ccc_core_model.sv
// behavioural analog core: tracks the input level while sampling
// assumes the controller reads the result only during the convert phase
`timescale 1ns/1ns

module ccc_core_model (
   input  wire logic       clk_in,
   input  wire logic       power_in,
   input  wire logic       sample_in,
   input  wire logic       convert_in,
   input  wire logic [9:0] level_in,
   output logic      [9:0] result_out = 10'h155
);
   logic [9:0] held = 10'h000;
   always @(posedge clk_in) begin
      if (sample_in)
         held <= level_in;
      // outside the convert phase the output toggles so a stray read cannot match
      if (convert_in && power_in)
         result_out <= held;
      else
         result_out <= ~result_out;
   end
endmodule

// >>> testbench.sv
// self-checking bench for the conversion control block
// assumes the core model in ccc_core_model.sv and a 125 MHz clock
`timescale 1ns/1ns

module testbench;
   logic                clk = 1'b0;
   logic                rst_n = 1'b0;
   logic [7:0]          addr = 8'h00;
   logic [7:0]          wdata = 8'h00;
   logic                wr_s = 1'b0;
   logic                rd_s = 1'b0;
   logic                gie = 1'b0;
   logic                vack = 1'b0;
   logic [7:0]          trig = 8'h00;
   logic [9:0]          level = 10'h000;
   logic [7:0]          rdata;
   logic                irq, power, tick, smp, cnv, run_d = 1'b0;
   logic [9:0]          res;
   ccc_pkg::ccc_route_s route;
   int                  seed = 32'h797eedf7;
   int                  fails = 0, samples_checked = 0;
   int                  len = 0, last_len = 0, starts = 0, cyc = 0;
   logic [7:0]          regs [8] = '{8'h70, 8'h71, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7f};

   ccc_conv_ctrl #(.TRIG_WIDTH(8)) uut (
      .MCLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .GLOBAL_IE_IN(gie),
      .VECTOR_ACK_IN(vack), .IRQ_OUT(irq), .TRIGGER_IN(trig), .ANA_RESULT_IN(res),
      .ANA_POWER_OUT(power), .ANA_TICK_OUT(tick), .ANA_SAMPLE_OUT(smp),
      .ANA_CONVERT_OUT(cnv), .ANA_ROUTE_OUT(route));
   ccc_core_model core (.clk_in(clk), .power_in(power), .sample_in(smp),
      .convert_in(cnv), .level_in(level), .result_out(res));

   initial forever #4 clk = ~clk;

   // run length and start count seen at the core; also the hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      run_d <= smp | cnv;
      if (smp | cnv)
         len <= len + 1;
      else if (len != 0) begin
         last_len <= len;
         len <= 0;
      end
      if ((smp | cnv) && !run_d)
         starts <= starts + 1;
      if (cyc == 40000) begin
         fails++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // tasks and expectations
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   // polls the control register; bounded so a stuck bit ends as a mismatch
   task automatic wait_bit(input int b, input logic v);
      logic [7:0] d = ~{8{v}};
      int n = 0;
      repeat (3) @(posedge clk);
      while (d[b] !== v && n < 3000) begin
         rd(8'h7a, d);
         n++;
      end
      chk(n < 3000, 1'b1);
      @(posedge clk);
   endtask
   function automatic int fac(input int d);
      return d < 2 ? 2 : 1 << d;
   endfunction
   // the tick phase is free, so a run lasts between (t-1)*f+1 and t*f cycles
   function automatic logic inr(input int n, input int t, input int f);
      return n > (t - 1) * f && n <= t * f;
   endfunction
   function automatic ccc_pkg::ccc_route_s exp_route(input logic [5:0] c);
      ccc_pkg::ccc_route_s e = '0;
      e.upper_valid = 1'b1;
      e.differential = 1'b1;
      e.code = c;
      e.reserved = c[5:1] == 5'b11111;
      if (c[4:3] == 2'b01) begin
         e.neg_input = c[2] ? 4'ha : 4'h8;
         e.pos_input = e.neg_input + {3'h0, c[0]};
         e.gain = c[1] ? ccc_pkg::CCC_GAIN_200 : ccc_pkg::CCC_GAIN_10;
      end else begin
         e.pos_input = {1'b1, c[2:0]};
         e.neg_input = c[3] ? 4'ha : 4'h9;
      end
      return e;
   endfunction

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] d;
      logic [5:0] c;
      logic [9:0] l1;
      ccc_pkg::ccc_route_s e;
      int s;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      foreach (regs[i]) rdc(regs[i], 8'h00);
      wr(8'h7f, 8'hff);
      rdc(8'h7f, 8'h00);
      wr(8'h7c, 8'h3f);
      rdc(8'h7c, 8'h3f);
      wr(8'h7a, 8'h40);
      rdc(8'h7a, 8'h00);
      for (int i = 0; i < 8; i++) begin
         d = 8'(i);
         s = starts;
         wr(8'h7a, 8'hc0 | d);
         rdc(8'h7a, 8'hc0 | d);
         wait_bit(6, 1'b0);
         chk(inr(last_len, 25, fac(i)), 1'b1);
         rdc(8'h7a, 8'h90 | d);
         wr(8'h7a, 8'h80 | d);
         rdc(8'h7a, 8'h90 | d);
         wr(8'h7a, 8'h90 | d);
         rdc(8'h7a, 8'h80 | d);
         wr(8'h7a, 8'hc0 | d);
         wr(8'h7a, 8'h80 | d);
         wait_bit(6, 1'b0);
         chk(inr(last_len, 13, fac(i)), 1'b1);
         chk(starts, s + 2);
         wr(8'h7a, 8'h10);
      end
      wr(8'h7b, 8'h03);
      wr(8'h7a, 8'ha0);
      s = starts;
      repeat (20) @(posedge clk) trig <= 8'($random(seed)) & 8'hf7;
      @(posedge clk) trig <= 8'h00;
      repeat (3) @(posedge clk);
      chk(starts, s);
      @(posedge clk) trig <= 8'h08;
      wait_bit(6, 1'b0);
      chk(starts, s + 1);
      chk(inr(last_len, 25, 2), 1'b1);
      @(posedge clk) trig <= 8'h00;
      wr(8'h7b, 8'h00);
      repeat (30) @(posedge clk);
      chk(starts, s + 1);
      wr(8'h71, 8'h02);
      gie <= 1'b1;
      wr(8'h7a, 8'hf0);
      repeat (2) begin
         wait_bit(4, 1'b1);
         wr(8'h7a, 8'hb0);
      end
      rdc(8'h7a, 8'he0);
      wr(8'h7a, 8'h00);
      @(negedge clk);
      chk(smp | cnv, 1'b0);
      rdc(8'h70, 8'h02);
      chk(irq, 1'b1);
      wr(8'h70, 8'h02);
      @(negedge clk);
      chk(irq, 1'b0);
      wr(8'h71, 8'h00);
      for (int k = 8'h28; k < 8'h40; k++) begin
         c = 6'(k);
         e = exp_route(c);
         wr(8'h7b, {4'h0, c[5], 3'h0});
         wr(8'h7c, {3'h0, c[4:0]});
         level <= 10'($random(seed));
         gie <= 1'($random(seed));
         wr(8'h7a, 8'hc8);
         wait_bit(6, 1'b0);
         if (e.reserved)
            chk({route.upper_valid, route.reserved, route.code}, {2'b11, c});
         else
            chk(route, e);
         rdc(8'h78, level[7:0]);
         rdc(8'h79, {6'h0, level[9:8]});
         chk(irq, gie);
         @(posedge clk) vack <= 1'b1;
         @(posedge clk) vack <= 1'b0;
         rdc(8'h7a, 8'h88);
         chk(irq, 1'b0);
      end
      l1 = level;
      wr(8'h7c, 8'h08);
      wr(8'h7a, 8'hc8);
      wr(8'h7c, 8'h09);
      chk(route.code, 6'h28);
      wait_bit(6, 1'b0);
      rdc(8'h78, l1[7:0]);
      @(posedge clk) level <= ~l1;
      wr(8'h7a, 8'hd8);
      wait_bit(6, 1'b0);
      chk(route.code, 6'h29);
      rdc(8'h79, {6'h0, l1[9:8]});
      rdc(8'h78, l1[7:0]);
      wr(8'h7c, 8'h29);
      rdc(8'h79, l1[9:2]);
      rdc(8'h78, {l1[1:0], 6'h00});
      report_and_stop();
   end
endmodule
